// File: hdl/pfd_lock_pkg.sv
package pfd_lock_pkg;

  // register offsets
  localparam logic [3:0] LOCK_DETECT_CONFIG_ADDR    = 4'h7;
  localparam logic [3:0] DETECTOR_TEST_CONTROL_ADDR = 4'hb;
  localparam logic [3:0] LOCK_STATUS_ADDR           = 4'hf;

  localparam int REG_W = 24;

  // lock_detect_config fields
  localparam int LKD_ENABLE_BIT     = 0;
  localparam int WIN_SRC_SEL_BIT    = 1;
  localparam int OSC_SPEED_LSB      = 2;
  localparam int OSC_SPEED_W        = 3;
  localparam int WIN_LEN_LSB        = 5;
  localparam int WIN_LEN_W          = 4;
  localparam int WIN_ASYM_EN_BIT    = 9;
  localparam int WIN_DELAY_SIDE_BIT = 10;
  localparam int LOCK_TARGET_LSB    = 12;
  localparam int LOCK_TARGET_W      = 12;

  // detector_test_control fields
  localparam int POL_INVERT_BIT      = 0;
  localparam int PUMP_UP_ALLOW_BIT   = 1;
  localparam int PUMP_DOWN_ALLOW_BIT = 2;
  localparam int FLAG_PIN_DRIVE_BIT  = 3;

  // lock_status fields
  localparam int LOCKED_BIT = 0;

  // reset values
  localparam logic [23:0] LOCK_DETECT_CONFIG_RST    = 24'h00_0000;
  localparam logic [23:0] DETECTOR_TEST_CONTROL_RST = 24'h00_000e;

  // timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int ANALOG_WIN_NS  = 10;
  localparam int ANALOG_WIN_CYC_RAW =
    (ANALOG_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ANALOG_WIN_CYC =
    (ANALOG_WIN_CYC_RAW < 1) ? 1 : ANALOG_WIN_CYC_RAW;

  localparam int TIME_W = 16;

endpackage : pfd_lock_pkg

// File: hdl/lock_window_calc.sv
`timescale 1ns/1ps

// turns the window settings into lag and lead limits in clock cycles
module lock_window_calc
  import pfd_lock_pkg::*;
(
  // window settings
  input  wire logic                   win_src_sel_in,
  input  wire logic [OSC_SPEED_W-1:0] osc_speed_in,
  input  wire logic [WIN_LEN_W-1:0]   win_len_in,
  input  wire logic                   asym_en_in,
  input  wire logic                   delay_side_in,
  // limits
  output logic      [TIME_W-1:0]      lag_lim_out,
  output logic      [TIME_W-1:0]      lead_lim_out
);

  logic [TIME_W-1:0] half;
  logic [TIME_W-1:0] ring_per;
  logic [TIME_W-1:0] ring_len;

  always_comb begin
    // ring period in clocks grows with the speed code
    ring_per = TIME_W'(osc_speed_in) + TIME_W'(1);
    ring_len = TIME_W'(ring_per * TIME_W'(win_len_in));
    if (win_src_sel_in) begin
      half = (ring_len == '0) ? TIME_W'(1) : ring_len;
    end else begin
      half = TIME_W'(ANALOG_WIN_CYC);
    end
    if (!asym_en_in) begin
      lag_lim_out  = half;
      lead_lim_out = half;
    end else if (delay_side_in) begin
      lag_lim_out  = TIME_W'(half << 1);
      lead_lim_out = '0;
    end else begin
      lag_lim_out  = '0;
      lead_lim_out = TIME_W'(half << 1);
    end
  end

endmodule : lock_window_calc

// File: hdl/lock_hit_counter.sv
`timescale 1ns/1ps

// consecutive in-window counter and lock flag
module lock_hit_counter
  import pfd_lock_pkg::*;
#(
  parameter int CNT_W = LOCK_TARGET_W
)
(
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_b_in,
  // control
  input  wire logic             enable_in,
  input  wire logic [CNT_W-1:0] target_in,
  // arrival verdicts
  input  wire logic             hit_in,
  input  wire logic             miss_in,
  // result
  output logic                  locked_out
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             locked;
  } hit_state_t;

  hit_state_t st_r;
  hit_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!enable_in) begin
      st_nxt.cnt    = '0;
      st_nxt.locked = 1'b0;
    end else if (miss_in) begin
      st_nxt.cnt    = '0;
      st_nxt.locked = 1'b0;
    end else if (hit_in) begin
      if (st_r.cnt < target_in) begin
        st_nxt.cnt = st_r.cnt + CNT_W'(1);
      end
      if (st_r.cnt + CNT_W'(1) >= target_in) begin
        st_nxt.locked = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign locked_out = st_r.locked;

endmodule : lock_hit_counter

// File: hdl/pfd_lock_detect.sv
`timescale 1ns/1ps

module pfd_lock_detect
  import pfd_lock_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              rst_b_in,
  // divider edges
  input  wire logic              ref_edge_in,
  input  wire logic              vco_edge_in,
  // register port from serial interface
  input  wire logic              reg_wr_en_in,
  input  wire logic              reg_rd_en_in,
  input  wire logic [3:0]        reg_addr_in,
  input  wire logic [REG_W-1:0]  reg_wdata_in,
  output logic      [REG_W-1:0]  reg_rdata_out,
  // serial read data for the shared pin
  input  wire logic              sdo_read_active_in,
  input  wire logic              sdo_data_in,
  // charge pump
  output logic                   pump_up_out,
  output logic                   pump_dn_out,
  output logic                   pump_active_out,
  // shared lock flag / serial out pin
  output logic                   lockflag_serialout_pin_out,
  output logic                   lockflag_serialout_pin_oe_out,
  // lock status
  output logic                   lock_flag_out
);

  typedef struct packed {
    logic [REG_W-1:0]  cfg;
    logic [REG_W-1:0]  test;
    logic [REG_W-1:0]  rdata;
    logic              up;
    logic              dn;
    logic              pump_up;
    logic              pump_dn;
    logic              pump_act;
    logic [TIME_W-1:0] since_ref;
    logic              ref_seen;
    logic [TIME_W-1:0] since_vco;
    logic              pending;
    logic              hit;
    logic              miss;
    logic              pin_o;
    logic              pin_oe;
  } top_state_t;

  top_state_t st_r;
  top_state_t st_nxt;

  logic [TIME_W-1:0]        lag_lim;
  logic [TIME_W-1:0]        lead_lim;
  logic                     locked;
  logic                     lkd_en;
  logic                     mask_up;
  logic                     mask_dn;

  function automatic logic [REG_W-1:0] read_mux(
    input logic [3:0]       addr,
    input logic [REG_W-1:0] cfg,
    input logic [REG_W-1:0] test,
    input logic             lk
  );
    logic [REG_W-1:0] v;
    v = '0;
    case (addr)
      LOCK_DETECT_CONFIG_ADDR:    v = cfg;
      DETECTOR_TEST_CONTROL_ADDR: v = test;
      LOCK_STATUS_ADDR:           v[LOCKED_BIT] = lk;
      default:                    v = '0;
    endcase
    return v;
  endfunction : read_mux

  assign lkd_en = st_r.cfg[LKD_ENABLE_BIT];

  lock_window_calc u_window (
    .win_src_sel_in (st_r.cfg[WIN_SRC_SEL_BIT]),
    .osc_speed_in   (st_r.cfg[OSC_SPEED_LSB +: OSC_SPEED_W]),
    .win_len_in     (st_r.cfg[WIN_LEN_LSB +: WIN_LEN_W]),
    .asym_en_in     (st_r.cfg[WIN_ASYM_EN_BIT]),
    .delay_side_in  (st_r.cfg[WIN_DELAY_SIDE_BIT]),
    .lag_lim_out    (lag_lim),
    .lead_lim_out   (lead_lim)
  );

  lock_hit_counter #(
    .CNT_W (LOCK_TARGET_W)
  ) u_hits (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .enable_in  (lkd_en),
    .target_in  (st_r.cfg[LOCK_TARGET_LSB +: LOCK_TARGET_W]),
    .hit_in     (st_r.hit),
    .miss_in    (st_r.miss),
    .locked_out (locked)
  );

  always_comb begin
    st_nxt = st_r;
    mask_up = 1'b0;
    mask_dn = 1'b0;

    // register writes and reads
    if (reg_wr_en_in) begin
      case (reg_addr_in)
        LOCK_DETECT_CONFIG_ADDR:    st_nxt.cfg = reg_wdata_in;
        DETECTOR_TEST_CONTROL_ADDR: st_nxt.test = reg_wdata_in;
        default:                    st_nxt.cfg = st_r.cfg;
      endcase
    end
    if (reg_rd_en_in) begin
      st_nxt.rdata = read_mux(reg_addr_in, st_r.cfg, st_r.test, locked);
    end

    // phase frequency detector: ref sets up, vco sets down, both clear
    st_nxt.up = st_r.up | ref_edge_in;
    st_nxt.dn = st_r.dn | vco_edge_in;
    if (st_nxt.up && st_nxt.dn) begin
      st_nxt.up = 1'b0;
      st_nxt.dn = 1'b0;
    end

    // polarity swap then masking
    if (st_r.test[POL_INVERT_BIT]) begin
      mask_up = st_nxt.dn;
      mask_dn = st_nxt.up;
    end else begin
      mask_up = st_nxt.up;
      mask_dn = st_nxt.dn;
    end
    st_nxt.pump_up = mask_up & st_r.test[PUMP_UP_ALLOW_BIT];
    st_nxt.pump_dn = mask_dn & st_r.test[PUMP_DOWN_ALLOW_BIT];
    st_nxt.pump_act = st_r.test[PUMP_UP_ALLOW_BIT] |
                      st_r.test[PUMP_DOWN_ALLOW_BIT];

    // window test, independent of pump masking
    st_nxt.hit  = 1'b0;
    st_nxt.miss = 1'b0;
    if (ref_edge_in) begin
      st_nxt.since_ref = '0;
      st_nxt.ref_seen  = 1'b1;
    end else if (st_r.since_ref != '1) begin
      st_nxt.since_ref = st_r.since_ref + TIME_W'(1);
    end
    if (st_r.pending && st_r.since_vco != '1) begin
      st_nxt.since_vco = st_r.since_vco + TIME_W'(1);
    end

    if (!lkd_en) begin
      st_nxt.pending = 1'b0;
    end else if (st_r.pending) begin
      // vco came early; wait for the reference within the lead limit
      if (ref_edge_in && st_r.since_vco < lead_lim) begin
        st_nxt.hit     = 1'b1;
        st_nxt.pending = 1'b0;
      end else if (ref_edge_in || st_r.since_vco >= lead_lim) begin
        st_nxt.miss    = 1'b1;
        st_nxt.pending = 1'b0;
      end
      if (vco_edge_in && !st_nxt.hit) begin
        st_nxt.miss    = 1'b1;
        st_nxt.pending = 1'b0;
      end
    end else if (vco_edge_in) begin
      if (ref_edge_in ||
          (st_r.ref_seen && st_r.since_ref < lag_lim)) begin
        st_nxt.hit = 1'b1;
      end else if (lead_lim != '0) begin
        st_nxt.pending   = 1'b1;
        st_nxt.since_vco = '0;
      end else begin
        st_nxt.miss = 1'b1;
      end
    end

    // shared pin: serial data during reads, otherwise the flag
    if (sdo_read_active_in) begin
      st_nxt.pin_o  = sdo_data_in;
      st_nxt.pin_oe = 1'b1;
    end else begin
      st_nxt.pin_o  = locked;
      st_nxt.pin_oe = st_r.test[FLAG_PIN_DRIVE_BIT];
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r      <= '0;
      st_r.cfg  <= LOCK_DETECT_CONFIG_RST;
      st_r.test <= DETECTOR_TEST_CONTROL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_out                 = st_r.rdata;
  assign pump_up_out                   = st_r.pump_up;
  assign pump_dn_out                   = st_r.pump_dn;
  assign pump_active_out               = st_r.pump_act;
  assign lockflag_serialout_pin_out    = st_r.pin_o;
  assign lockflag_serialout_pin_oe_out = st_r.pin_oe;
  assign lock_flag_out                 = locked;

endmodule : pfd_lock_detect

// File: test/pfd_lock_properties.sv
`timescale 1ns/1ps
module pfd_lock_checker (
  input wire logic        sys_clk_in,
  input wire logic        rst_b_in,
  input wire logic        ref_edge_in,
  input wire logic        vco_edge_in,
  input wire logic        reg_wr_en_in,
  input wire logic        reg_rd_en_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [23:0] reg_wdata_in,
  input wire logic [23:0] reg_rdata_out,
  input wire logic        sdo_read_active_in,
  input wire logic        sdo_data_in,
  input wire logic        pump_up_out,
  input wire logic        pump_dn_out,
  input wire logic        pump_active_out,
  input wire logic        lockflag_serialout_pin_out,
  input wire logic        lockflag_serialout_pin_oe_out,
  input wire logic        lock_flag_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_idle;
    !pump_active_out |-> !pump_up_out && !pump_dn_out;
  endproperty
  a_idle: assert property (p_idle)
    else $error("pump drives while idle");
  property p_up;
    $changed(pump_up_out) |-> $past(ref_edge_in) || $past(vco_edge_in)
      || $past(reg_wr_en_in) || $past(reg_wr_en_in, 2);
  endproperty
  a_up: assert property (p_up)
    else $error("up output moved without cause");
  property p_dn;
    $changed(pump_dn_out) |-> $past(ref_edge_in) || $past(vco_edge_in)
      || $past(reg_wr_en_in) || $past(reg_wr_en_in, 2);
  endproperty
  a_dn: assert property (p_dn)
    else $error("down output moved without cause");
  property p_off;
    reg_wr_en_in && reg_addr_in == 4'h7 && !reg_wdata_in[0]
      |-> ##[1:2] !lock_flag_out;
  endproperty
  a_off: assert property (p_off)
    else $error("flag high while detection off");
  property p_stat;
    reg_rd_en_in && reg_addr_in == 4'hf
      |=> reg_rdata_out[0] == $past(lock_flag_out);
  endproperty
  a_stat: assert property (p_stat)
    else $error("status bit differs from flag");
  property p_pin_rd;
    $past(sdo_read_active_in) |-> lockflag_serialout_pin_oe_out
      && lockflag_serialout_pin_out == $past(sdo_data_in);
  endproperty
  a_pin_rd: assert property (p_pin_rd)
    else $error("pin lost read data");
  property p_pin_flag;
    !$past(sdo_read_active_in) && lockflag_serialout_pin_oe_out
      && $stable(lock_flag_out) |-> lockflag_serialout_pin_out == lock_flag_out;
  endproperty
  a_pin_flag: assert property (p_pin_flag)
    else $error("pin differs from flag");
  property p_rise;
    $rose(lock_flag_out) |-> $past(vco_edge_in, 2) || $past(ref_edge_in, 2);
  endproperty
  a_rise: assert property (p_rise)
    else $error("flag rose without arrival");
endmodule : pfd_lock_checker

bind pfd_lock_detect pfd_lock_checker pfd_lock_checker_inst (
  .sys_clk_in, .rst_b_in, .ref_edge_in, .vco_edge_in, .reg_wr_en_in,
  .reg_rd_en_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
  .sdo_read_active_in, .sdo_data_in, .pump_up_out, .pump_dn_out,
  .pump_active_out, .lockflag_serialout_pin_out,
  .lockflag_serialout_pin_oe_out, .lock_flag_out
);

// File: test/pfd_divider_model.sv
`timescale 1ns/1ps
// dividers: reference edge every 16 cycles, vco edge skew cycles later
module pfd_divider_model (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic [3:0] skew_in,
  output logic            ref_edge_out,
  output logic            vco_edge_out
);
  logic [3:0] cnt_r;
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) cnt_r <= 4'h0;
    else cnt_r <= cnt_r + 4'h1;
  end
  assign ref_edge_out = rst_b_in && cnt_r == 4'h0;
  assign vco_edge_out = rst_b_in && cnt_r == skew_in;
endmodule : pfd_divider_model

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clk, rst_b, wr, rd, sdo_act, sdo_d, ref_e, vco_e;
  logic        up, dn, act, pin, oe, lk;
  logic [3:0]  addr, skew;
  logic [23:0] wdata, rdata, rv;
  logic [31:0] seed = 32'h0000_7b23;
  logic [15:0] wc [12] = '{16'h0010, 16'h0013, 16'h0473, 16'h0478,
    16'h6476, 16'h647d, 16'h247d, 16'h2476, 16'h02f3, 16'h0233,
    16'h0011, 16'h2478};
  int          n_fail = 0;
  int          cmp_count = 0;
  int          i, t;
  pfd_lock_detect pfd_lock_detect_inst (
    .sys_clk_in(clk), .rst_b_in(rst_b), .ref_edge_in(ref_e),
    .vco_edge_in(vco_e), .reg_wr_en_in(wr), .reg_rd_en_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .sdo_read_active_in(sdo_act), .sdo_data_in(sdo_d),
    .pump_up_out(up), .pump_dn_out(dn), .pump_active_out(act),
    .lockflag_serialout_pin_out(pin),
    .lockflag_serialout_pin_oe_out(oe), .lock_flag_out(lk));
  pfd_divider_model pfd_divider_model_inst (.sys_clk_in(clk),
    .rst_b_in(rst_b), .skew_in(skew), .ref_edge_out(ref_e),
    .vco_edge_out(vco_e));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // upper twelve bits: low config bits, lower four: vco skew
  function automatic logic [23:0] exp_hit(logic [15:0] w);
    int h, lag, lead, s;
    s = int'(w[3:0]);
    h = w[5] ? int'(w[12:9]) * (int'(w[8:6]) + 1) : 1;
    if (h < 1) h = 1;
    lag = w[13] ? (w[14] ? 2 * h : 0) : h;
    lead = w[13] ? (w[14] ? 0 : 2 * h) : h;
    // an arrival exactly at the limit still counts as inside the window
    return 24'(s == 0 || s <= lag || 16 - s <= lead);
  endfunction : exp_hit
  function automatic logic [23:0] exp_pump(logic [3:0] b);
    return {20'h0_0000, ~b[0] & b[1], b[0] & b[2], b[1] | b[2], b[3]};
  endfunction : exp_pump
  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic wr_reg(logic [3:0] a, logic [23:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(logic [3:0] a, output logic [23:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    #1 d = rdata;
  endtask : rd_reg
  task automatic sync_ref();
    for (int k = 0; k < 40; k++) begin
      @(posedge clk);
      #1;
      if (ref_e === 1'b1) return;
    end
    n_fail++;
    conclude();
  endtask : sync_ref
  task automatic hold(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold
  initial begin
    {rst_b, wr, rd, sdo_act, sdo_d, addr, skew, wdata} = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(4'h7, rv);
    check("cfg", rv, 24'h00_0000);
    rd_reg(4'hb, rv);
    check("test", rv, 24'h00_000e);
    rd_reg(4'h3, rv);
    check("unmapped", rv, 24'h00_0000);
    skew <= 4'h4;
    for (i = 0; i < 16; i++) begin
      wr_reg(4'hb, 24'(i));
      sync_ref();
      hold(3);
      check("pump", 24'({up, dn, act, oe}), exp_pump(4'(i)));
    end
    wr_reg(4'hb, 24'h00_000e);
    $display("pump test done");
    for (i = 0; i < 12; i++) begin
      wr_reg(4'h7, {12'h004, wc[i][15:4]});
      skew <= wc[i][3:0];
      hold(112);
      check("win", 24'(lk), exp_hit(wc[i]));
    end
    $display("window test done");
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      t = 2 + int'(seed[2:0]);
      wr_reg(4'h7, {12'(t), 12'h001});
      skew <= 4'h8;
      hold(48);
      check("miss", 24'(lk), 24'h00_0000);
      skew <= 4'h0;
      hold((t - 1) * 16);
      check("early", 24'(lk), 24'h00_0000);
      hold((t + 2) * 16);
      check("lock", 24'(lk), 24'h00_0001);
    end
    $display("lock test done");
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      @(posedge clk);
      sdo_act <= 1'b1;
      sdo_d <= seed[0];
      hold(2);
      check("pin read", 24'({pin, oe}), 24'({seed[0], 1'b1}));
    end
    @(posedge clk);
    sdo_act <= 1'b0;
    hold(3);
    check("pin flag", 24'({pin, oe}), 24'h00_0003);
    wr_reg(4'hf, 24'h00_0000);
    rd_reg(4'hf, rv);
    check("status", rv, 24'h00_0001);
    $display("pin test done");
    wr_reg(4'h7, 24'h00_4000);
    hold(64);
    check("off", 24'(lk), 24'h00_0000);
    rd_reg(4'hf, rv);
    check("status off", rv, 24'h00_0000);
    $display("disable test done");
    conclude();
  end
endmodule : testbench
